// ### src/cibf_pkg.sv
// Package for the custom-instruction bit, byte and float unit.
// Assumes a single 250 MHz clock domain; nothing here is synthesised on its own.
package cibf_pkg;
    // Opcode extensions served by the float unit (fixed)
    localparam logic [7:0] OPX_FP_FIRST = 8'hfc;
    localparam logic [7:0] OPX_FP_ADD   = 8'hfc;
    localparam logic [7:0] OPX_FP_SUB   = 8'hfd;
    localparam logic [7:0] OPX_FP_MUL   = 8'hfe;
    localparam logic [7:0] OPX_FP_DIV   = 8'hff;
    // Opcode extensions chosen for the two reversal units
    localparam logic [7:0] OPX_BIT_REV  = 8'h00;
    localparam logic [7:0] OPX_BYTE_REV = 8'h01;
    // Single-precision field layout
    localparam int EXP_LSB   = 23;
    localparam int SIGN_BIT  = 31;
    localparam logic [7:0] EXP_BIAS = 8'h7f;
    localparam logic [7:0] EXP_MAX  = 8'hff;
    // Value after reset of the result register
    localparam logic [31:0] RESULT_RST = 32'h0000_0000;
    // Latency of every instruction, in clock cycles
    localparam int LATENCY_CYCLES = 1;
endpackage : cibf_pkg

// ### src/cibf_unit.sv
// Custom-instruction datapath: bit reversal, byte reversal, float add/sub/mul/div.
// Assumes the core holds operands and opcode steady while start is high and
// samples result on the cycle done is high; inputs are synchronous to sys_clk.
// Opcode map: 0x00 bit reversal, 0x01 byte reversal, 0xfc add, 0xfd subtract,
// 0xfe multiply, 0xff divide; every other opcode answers zero.
// Float limits, traded for a one-cycle answer: denormals flush to zero,
// rounding truncates, overflow saturates to infinity, NaN and infinity pass
// through without full checks, and divide by zero gives a signed infinity.
// With the divide option off the divide opcode answers zero and never stalls.
//
// What this block does
// - Bit reversal returns the 32-bit operand with its bit order reversed, one cycle after issue.
// - Byte reversal returns the 32-bit operand with its four bytes swapped end for end in one cycle.
// - Byte reversal touches only the word passed in; no other ordering in the core changes.
// - The float operations answer only to opcode extensions 252 to 255, which are fixed.
// - Float add, subtract and multiply always exist; divide exists only when its option is on.
// - The divide option is off by default.
// - The slave side is two operands, an opcode, a clock, its enable, a reset, start, a result and done; all but result and done are inputs driven by the core.
`timescale 1ns/100ps
module cibf_unit #(
    parameter bit USE_DIV = 1'b0
) (
    // Clock, reset, enable
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    // Instruction issue
    input  wire logic        start,
    input  wire logic [7:0]  opx,
    input  wire logic [31:0] dataa,
    input  wire logic [31:0] datab,
    // Answer
    output logic      [31:0] result,
    output logic             done
);
    // Reset chain
    logic        rst_meta;
    logic        rst_sync_n;
    logic        next_rst_meta;
    logic        next_rst_sync_n;
    // Next values of the answer registers
    logic [31:0] next_result;
    logic        next_done;
    // Combinational words feeding the result select
    logic [31:0] rev_bits;
    logic [31:0] rev_bytes;
    logic [31:0] quot;
    logic [31:0] fp_word;
    logic [31:0] rev_word;

    // Reset chain next values; the first flop only ever feeds the second
    always_comb begin
        next_rst_meta   = 1'b1;
        next_rst_sync_n = rst_meta;
    end

    // Reset release through two flops; assert is asynchronous, release is
    // synchronous so no flop past these two sees rst_n rise close to a clock edge
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta   <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta   <= next_rst_meta;
            rst_sync_n <= next_rst_sync_n;
        end
    end

    // Bit reversal is pure wiring, no gates, so it fits one cycle easily;
    // datab never reaches it
    for (genvar gi = 0; gi < 32; gi++) begin : g_bit_rev
        assign rev_bits[31-gi] = dataa[gi];
    end

    // Byte reversal: lane k of the answer takes lane 3-k of the operand.
    // Only this word is reordered; the core keeps its own byte order.
    for (genvar gk = 0; gk < 4; gk++) begin : g_byte_rev
        assign rev_bytes[8*(3-gk) +: 8] = dataa[8*gk +: 8];
    end

    // Pack sign/exponent/mantissa, saturating to infinity or flushing to zero
    // Exponent arrives wide and signed so overflow and underflow stay visible
    function automatic logic [31:0] fp_pack(input logic s, input logic signed [10:0] e,
                                            input logic [22:0] m);
        if (e >= 11'sd255)
            return {s, cibf_pkg::EXP_MAX, 23'h000000};
        else if (e <= 11'sd0)
            return {s, 31'h0000_0000};
        else
            return {s, e[7:0], m};
    endfunction : fp_pack

    // Add or subtract; denormals flushed, truncating rounding to keep one cycle
    function automatic logic [31:0] fp_add(input logic [31:0] a, input logic [31:0] b);
        logic [7:0]  ea;
        logic [7:0]  eb;
        logic [7:0]  d;
        logic [25:0] ma;
        logic [25:0] mb;
        logic [25:0] s;
        logic        sg;
        logic signed [10:0] e;
        int          lz;
        ea = a[30:23];
        eb = b[30:23];
        if (ea == 8'h00) return b;
        if (eb == 8'h00) return a;
        if (ea == cibf_pkg::EXP_MAX || eb == cibf_pkg::EXP_MAX)
            return (ea == cibf_pkg::EXP_MAX) ? a : b;
        // Larger magnitude first, so the mantissa difference never goes negative
        if ({ea, a[22:0]} < {eb, b[22:0]}) begin
            {a, b} = {b, a};
            {ea, eb} = {eb, ea};
        end
        // Bit 25 catches the carry, bit 24 holds the hidden one, bit 0 a guard
        d  = ea - eb;
        ma = {1'b0, 1'b1, a[22:0], 1'b0};
        mb = (d > 8'h19) ? 26'h0 : ({1'b0, 1'b1, b[22:0], 1'b0} >> d);
        sg = a[cibf_pkg::SIGN_BIT];
        s  = (a[31] == b[31]) ? ma + mb : ma - mb;
        if (s == 26'h0) return 32'h0000_0000;
        // Leading-zero count renormalises after cancellation
        lz = 0;
        for (int i = 25; i >= 0; i--) begin
            if (s[i] == 1'b0 && lz == 25 - i) lz++;
        end
        s = s << lz;
        e = 11'(signed'({3'b000, ea})) + 11'sd1 - 11'(lz);
        return fp_pack(sg, e, s[24:2]);
    endfunction : fp_add

    // Multiply with truncation
    // Two 1.x mantissas give a product in [1,4); bit 47 picks the scale
    function automatic logic [31:0] fp_mul(input logic [31:0] a, input logic [31:0] b);
        logic [47:0] p;
        logic        sg;
        logic signed [10:0] e;
        sg = a[31] ^ b[31];
        if (a[30:23] == 8'h00 || b[30:23] == 8'h00) return {sg, 31'h0000_0000};
        p = {1'b1, a[22:0]} * {1'b1, b[22:0]};
        e = 11'(a[30:23]) + 11'(b[30:23]) - 11'(cibf_pkg::EXP_BIAS);
        if (p[47]) return fp_pack(sg, e + 11'sd1, p[46:24]);
        return fp_pack(sg, e, p[45:23]);
    endfunction : fp_mul

    // Divide with truncation; divide by zero gives infinity
    // Two 1.x mantissas give a quotient in (0.5,2); bit 26 picks the scale
    function automatic logic [31:0] fp_div(input logic [31:0] a, input logic [31:0] b);
        logic [49:0] q;
        logic        sg;
        logic signed [10:0] e;
        sg = a[31] ^ b[31];
        if (b[30:23] == 8'h00) return {sg, cibf_pkg::EXP_MAX, 23'h000000};
        if (a[30:23] == 8'h00) return {sg, 31'h0000_0000};
        q = {1'b1, a[22:0], 26'h0} / {26'h0, 1'b1, b[22:0]};
        e = 11'(a[30:23]) - 11'(b[30:23]) + 11'(cibf_pkg::EXP_BIAS);
        if (q[26]) return fp_pack(sg, e, q[25:3]);
        return fp_pack(sg, e - 11'sd1, q[24:2]);
    endfunction : fp_div

    // Divide hardware is built only with the option on; with it off the
    // opcode still answers, with zero, so the core never waits on it
    if (USE_DIV) begin : g_div_on
        assign quot = fp_div(dataa, datab);
    end else begin : g_div_off
        assign quot = 32'h0000_0000;
    end

    // Float answer for the four fixed opcodes; others give zero
    always_comb begin
        case (opx)
            cibf_pkg::OPX_FP_ADD: fp_word = fp_add(dataa, datab);
            cibf_pkg::OPX_FP_SUB: fp_word = fp_add(dataa, datab ^ 32'h8000_0000);
            cibf_pkg::OPX_FP_MUL: fp_word = fp_mul(dataa, datab);
            cibf_pkg::OPX_FP_DIV: fp_word = quot;
            default:              fp_word = 32'h0000_0000;
        endcase
    end

    // Reversal answer for the two chosen opcodes; others give zero
    always_comb begin
        case (opx)
            cibf_pkg::OPX_BIT_REV:  rev_word = rev_bits;
            cibf_pkg::OPX_BYTE_REV: rev_word = rev_bytes;
            default:                rev_word = 32'h0000_0000;
        endcase
    end

    // Next result: float only inside the fixed 0xfc..0xff window; unknown
    // opcodes answer zero rather than hold, so a stray issue is visible
    always_comb begin
        next_result = result;
        if (start) begin
            if (opx >= cibf_pkg::OPX_FP_FIRST) begin
                next_result = fp_word;
            end else begin
                next_result = rev_word;
            end
        end
    end

    // Done group: one pulse for each taken issue
    always_comb begin
        next_done = start;
    end

    // Result register; one cycle from issue to answer, frozen while clk_en low
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            result <= cibf_pkg::RESULT_RST;
        end else if (clk_en) begin
            result <= next_result;
        end
    end

    // Done register; stands one cycle unless clk_en freezes it
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            done <= 1'b0;
        end else if (clk_en) begin
            done <= next_done;
        end
    end
endmodule : cibf_unit

// ### dv/cibf_asserts.sv
// Checker for the custom-instruction unit, bound onto cibf_unit.
// Assumes operands stay steady at the issuing edge.
`timescale 1ns/100ps
module cibf_asserts #(parameter bit USE_DIV = 1'b0) (
    input wire logic        sys_clk, rst_n, clk_en, start, done,
    input wire logic [7:0]  opx,
    input wire logic [31:0] dataa, datab, result
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic        issue;
    logic [31:0] bit_rev, byte_rev;
    // Reference reversals, kept apart from the design's own code
    assign issue    = start && clk_en;
    assign bit_rev  = {<<{dataa}};
    assign byte_rev = {<<8{dataa}};
    bit_rev_a:
    assert property (issue && opx == cibf_pkg::OPX_BIT_REV |=> done && result == $past(bit_rev))
        else $error("bit reversal wrong");
    byte_rev_a:
    assert property (issue && opx == cibf_pkg::OPX_BYTE_REV |=> result == $past(byte_rev))
        else $error("byte reversal wrong");
    div_absent_a:
    assert property (issue && opx == cibf_pkg::OPX_FP_DIV && !USE_DIV |=> result == 32'h0)
        else $error("divide answered while omitted");
    opx_range_a:
    assert property (issue && opx inside {[8'h02:8'hfb]} |=> result == 32'h0)
        else $error("unused opcode answered");
    done_cause_a:
    assert property (done |-> $past(issue) || ($past(done) && !$past(clk_en)))
        else $error("done without issue");
    done_follows_a:
    assert property (issue |=> done) else $error("done missing after issue");
    result_hold_a:
    assert property (!issue |=> $stable(result)) else $error("result moved while idle");
    mul_zero_a:
    assert property (issue && opx == cibf_pkg::OPX_FP_MUL && dataa == 32'h0
        && datab[30:23] != 8'hff |=> result == {$past(datab[31]), 31'h0})
        else $error("multiply by zero wrong");
    // Main scenarios reached
    cover property (issue && opx == cibf_pkg::OPX_FP_ADD);
    cover property (issue && opx == cibf_pkg::OPX_FP_DIV);
    cover property (start && !clk_en);
endmodule : cibf_asserts
bind cibf_unit cibf_asserts #(.USE_DIV(USE_DIV)) cibf_asserts_inst (.sys_clk(sys_clk),
    .rst_n(rst_n), .clk_en(clk_en), .start(start), .done(done), .opx(opx),
    .dataa(dataa), .datab(datab), .result(result));

// ### dv/cibf_core_model.sv
// Model of the issuing core on the custom-instruction slave side.
// Assumes a free-running sys_clk; one instruction at a time.
`timescale 1ns/100ps
module cibf_core_model (
    input wire logic        sys_clk,
    output logic            clk_en, start,
    output logic [7:0]      opx,
    output logic [31:0]     dataa, datab,
    input wire logic [31:0] result,
    input wire logic        done
);
    initial begin
        clk_en = 1'b1; start = 1'b0; opx = 8'h00; dataa = 32'h0; datab = 32'h0;
    end
    // Issue one opcode, then read the answer in its one-cycle window
    task automatic issue(input logic en, input logic [7:0] op, input logic [31:0] a, b,
                         output logic [31:0] r, output logic d);
        @(posedge sys_clk);
        clk_en <= en; start <= 1'b1; opx <= op; dataa <= a; datab <= b;
        @(posedge sys_clk);
        // Released operands go inverted so a stale value never passes
        clk_en <= 1'b1; start <= 1'b0; dataa <= ~a; datab <= ~b;
        @(negedge sys_clk);
        r = result;
        d = done;
    endtask : issue
endmodule : cibf_core_model

// ### dv/tb_top.sv
// Self-checking bench for cibf_unit with the core model driving it.
// Assumes the default build, divide omitted, plus a divide-enabled build alongside.
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin n_fail++; \
    $display("unexpected %s exp %h got %h", nm, exp, got); end end
module tb_top;
    logic        sys_clk = 1'b0, rst_n = 1'b0, clk_en, start, done, d;
    logic [7:0]  opx;
    logic [31:0] dataa, datab, result, r;
    logic [31:0] result_div;
    logic        done_div;
    int          n_fail = 0, checks_done = 0;
    always #2 sys_clk = ~sys_clk;
    cibf_unit cibf_unit_inst (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
        .start(start), .opx(opx), .dataa(dataa), .datab(datab), .result(result), .done(done));
    cibf_core_model cibf_core_model_inst (.sys_clk(sys_clk), .clk_en(clk_en), .start(start),
        .opx(opx), .dataa(dataa), .datab(datab), .result(result), .done(done));
    // Divide-enabled build on the same inputs, so the option is exercised too
    if (1) begin : g_div_build
        cibf_unit #(.USE_DIV(1'b1)) cibf_unit_inst (.sys_clk(sys_clk), .rst_n(rst_n),
            .clk_en(clk_en), .start(start), .opx(opx), .dataa(dataa), .datab(datab),
            .result(result_div), .done(done_div));
    end
    // One issue and its two comparisons
    task automatic run(input logic en, input logic [7:0] op, input logic [31:0] a, b, exp);
        cibf_core_model_inst.issue(en, op, a, b, r, d);
        `CHK("done", en, d)
        `CHK("result", exp, r)
    endtask : run
    task automatic test_bitrev;
        run(1'b1, cibf_pkg::OPX_BIT_REV, 32'h1234_5678, 32'hffff_ffff, 32'h1e6a_2c48);
        run(1'b1, cibf_pkg::OPX_BIT_REV, 32'h0000_0001, 32'h0, 32'h8000_0000);
    endtask : test_bitrev
    task automatic test_byterev;
        run(1'b1, cibf_pkg::OPX_BYTE_REV, 32'h1234_5678, 32'ha5a5_a5a5, 32'h7856_3412);
        run(1'b1, cibf_pkg::OPX_BYTE_REV, 32'h0000_00ff, 32'h0, 32'hff00_0000);
    endtask : test_byterev
    task automatic test_float;
        run(1'b1, cibf_pkg::OPX_FP_ADD, 32'h3f80_0000, 32'h4000_0000, 32'h4040_0000);
        run(1'b1, cibf_pkg::OPX_FP_SUB, 32'h4040_0000, 32'h3f80_0000, 32'h4000_0000);
        run(1'b1, cibf_pkg::OPX_FP_MUL, 32'h4000_0000, 32'h4040_0000, 32'h40c0_0000);
        run(1'b1, cibf_pkg::OPX_FP_MUL, 32'h0, 32'hc040_0000, 32'h8000_0000);
    endtask : test_float
    task automatic test_div_off;
        run(1'b1, cibf_pkg::OPX_FP_DIV, 32'h4040_0000, 32'h3f80_0000, 32'h0);
        `CHK("div result", 32'h4040_0000, result_div)
        `CHK("div done", 1'b1, done_div)
        run(1'b1, cibf_pkg::OPX_FP_DIV, 32'h3f80_0000, 32'h3fc0_0000, 32'h0);
        `CHK("div result", 32'h3f2a_aaaa, result_div)
    endtask : test_div_off
    task automatic test_unused;
        run(1'b1, 8'h02, 32'h4040_0000, 32'h3f80_0000, 32'h0);
        run(1'b1, 8'hfb, 32'h4040_0000, 32'h3f80_0000, 32'h0);
    endtask : test_unused
    task automatic test_hold;
        run(1'b1, cibf_pkg::OPX_BIT_REV, 32'h0000_0002, 32'h0, 32'h4000_0000);
        run(1'b0, cibf_pkg::OPX_BYTE_REV, 32'h1234_5678, 32'h0, 32'h4000_0000);
    endtask : test_hold
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : wrap_up
    // Watchdog far beyond the few dozen cycles the tests need
    initial begin
        #4000;
        n_fail++;
        wrap_up();
    end
    // Reset, then every scenario in turn
    initial begin
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        test_bitrev();
        test_byterev();
        test_float();
        test_div_off();
        test_unused();
        test_hold();
        wrap_up();
    end
endmodule : tb_top
